// File: rscs_map.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 100 MHz i_mclk
// Notes:   Definitions only
`ifndef RSCS_MAP_SVH
`define RSCS_MAP_SVH

// ****************************************
// Configuration word map
// ****************************************
`define RSCS_CFG_ADDR      14'h2007
`define RSCS_TEST_LO       14'h2000
`define RSCS_TEST_HI       14'h3fff
`define RSCS_CFG_W         14
`define RSCS_OSC_LSB       0
`define RSCS_OSC_MSB       1
`define RSCS_EXT_RESET_PIN_ENABLE_BIT     2
`define RSCS_RSV_LSB       3
`define RSCS_RSV_MSB       10
`define RSCS_UNIMP_LSB     11
`define RSCS_UNIMP_MSB     13
`define RSCS_CFG_ERASED    14'h07ff
`define RSCS_CFG_WMASK     14'h0007
`define RSCS_CFG_RDMASK    14'h07ff

// ****************************************
// Timing
// ****************************************
`define RSCS_CLK_MHZ       100
`define RSCS_POWER_UP_DELAY_TIMER_TIME_MS  72
`define RSCS_POWER_UP_DELAY_TIMER_CYCLES   (`RSCS_POWER_UP_DELAY_TIMER_TIME_MS * 1000 * `RSCS_CLK_MHZ)
`define RSCS_OST_PERIODS   10'h200
`define RSCS_OST_LIMIT     704
`define RSCS_IDLE_BITS     11'h580
`define RSCS_FILT_CYCLES   3'h4

`endif

// File: rscs_pkg.sv
// Purpose: Types of the reset and sleep sequencer
// Assumes: Constants live in rscs_map.svh
// Notes:   No timescale in packages
package rscs_pkg;

  typedef enum logic [2:0] {
    ST_POWER_UP_DELAY_TIMER  = 3'h0,
    ST_OST   = 3'h1,
    ST_RUN   = 3'h3,
    ST_SLEEP = 3'h2,
    ST_WAKE  = 3'h6,
    ST_EXTRS = 3'h4
  } rscs_state_t;

  typedef enum logic [1:0] {
    OSC_LOW_POWER_CRYSTAL  = 2'h0,
    OSC_STANDARD_CRYSTAL   = 2'h1,
    OSC_TEST_EXT_CLOCK     = 2'h2,
    OSC_HIGH_SPEED_CRYSTAL = 2'h3
  } rscs_osc_t;

endpackage

// File: rscs_sequencer.sv
// Purpose: Reset, start-up, sleep and programming-entry sequencing
// Assumes: i_srst is the power-on reset; pins are asynchronous
// Notes:   Configuration word has no reset, like nonvolatile cells
`timescale 1ns/1ns
`include "rscs_map.svh"

module rscs_sequencer #(
  parameter int unsigned POWER_UP_DELAY_TIMER_CYCLES = `RSCS_POWER_UP_DELAY_TIMER_CYCLES
) (
  input  wire logic                  i_mclk,
  input  wire logic                  i_srst,
  input  wire logic                  i_prog_voltage_pin,
  input  wire logic                  i_prog_data_pin,
  input  wire logic                  i_prog_clock_pin,
  input  wire logic                  i_can_rx_pin,
  input  wire logic [7:0]            i_gpio_pin,
  input  wire logic [7:0]            i_change_enable,
  input  wire logic                  i_osc_tick,
  input  wire logic                  i_bit_tick,
  input  wire logic                  i_normal_mode,
  input  wire logic                  i_msg_valid,
  input  wire logic                  i_sleep_enable_bit,
  input  wire logic                  i_sleep_after_powerup_bit,
  input  wire logic [7:0]            i_core_gpio_out,
  input  wire logic [7:0]            i_core_gpio_oe,
  input  wire logic [13:0]           i_cfg_addr,
  input  wire logic [13:0]           i_cfg_wdata,
  input  wire logic                  i_cfg_wr,
  input  wire logic                  i_cfg_erase,
  output logic      [13:0]           o_cfg_rdata,
  output logic                       o_prog_mode,
  output logic                       o_prog_data,
  output logic                       o_prog_clock,
  output rscs_pkg::rscs_osc_t        o_osc_mode,
  output logic                       o_core_reset,
  output logic                       o_sleep,
  output logic                       o_periph_halt,
  output logic                       o_listen_only,
  output logic                       o_drop_wake_frame,
  output logic [7:0]                 o_gpio_out,
  output logic [7:0]                 o_gpio_oe,
  output rscs_pkg::rscs_state_t      o_state
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [12:0] sync1;
  logic [12:0] sync2;
  logic [7:0]  gpio_prev;
  logic        vpp_prev;

  always_ff @(posedge i_mclk) begin
    sync1 <= {i_can_rx_pin, i_prog_clock_pin, i_prog_data_pin, i_prog_voltage_pin,
              i_gpio_pin[7], i_gpio_pin};
    sync2 <= sync1;
  end

  logic       rx_s;
  logic       pclk_s;
  logic       pdat_s;
  logic       vpp_s;
  logic       rst_n_s;
  logic [7:0] gpio_s;
  assign rx_s    = sync2[12];
  assign pclk_s  = sync2[11];
  assign pdat_s  = sync2[10];
  assign vpp_s   = sync2[9];
  assign rst_n_s = sync2[8];
  assign gpio_s  = sync2[7:0];

  always_ff @(posedge i_mclk) begin
    gpio_prev <= gpio_s;
    vpp_prev  <= vpp_s;
  end

  // ****************************************
  // Configuration word
  // ****************************************
  logic [13:0] cfg_word;
  logic        prog_mode;

  // Unprogrammed bit reads 1, programmed 0; no reset on this storage
  always_ff @(posedge i_mclk) begin
    if (prog_mode && i_cfg_erase) begin
      cfg_word <= `RSCS_CFG_ERASED;
    end else if (prog_mode && i_cfg_wr && i_cfg_addr == `RSCS_CFG_ADDR) begin
      cfg_word <= (cfg_word & ~`RSCS_CFG_WMASK) | (i_cfg_wdata & `RSCS_CFG_WMASK);
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_cfg_rdata <= 14'h0000;
    end else if (prog_mode && i_cfg_addr == `RSCS_CFG_ADDR) begin
      o_cfg_rdata <= cfg_word & `RSCS_CFG_RDMASK;
    end else begin
      o_cfg_rdata <= 14'h0000;
    end
  end

  logic ext_rst_en;
  assign ext_rst_en = cfg_word[`RSCS_EXT_RESET_PIN_ENABLE_BIT];
  assign o_osc_mode = rscs_pkg::rscs_osc_t'(cfg_word[`RSCS_OSC_MSB:`RSCS_OSC_LSB]);

  // ****************************************
  // Program mode entry
  // ****************************************
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      prog_mode <= 1'b0;
    end else if (!vpp_s) begin
      prog_mode <= 1'b0;
    end else if (!vpp_prev && !pdat_s && !pclk_s) begin
      prog_mode <= 1'b1;
    end
  end

  assign o_prog_mode = prog_mode;

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_prog_data  <= 1'b0;
      o_prog_clock <= 1'b0;
    end else begin
      o_prog_data  <= prog_mode & pdat_s;
      o_prog_clock <= prog_mode & pclk_s;
    end
  end

  // ****************************************
  // External reset glitch filter
  // ****************************************
  logic [2:0] filt_cnt;
  logic       ext_rst;

  // Low must persist 5 cycles (FILT + 1) before it counts as a reset
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      filt_cnt <= 3'h0;
      ext_rst  <= 1'b0;
    end else if (!ext_rst_en || prog_mode || rst_n_s) begin
      filt_cnt <= 3'h0;
      ext_rst  <= 1'b0;
    end else if (filt_cnt != `RSCS_FILT_CYCLES) begin
      filt_cnt <= filt_cnt + 3'h1;
    end else begin
      ext_rst <= 1'b1;
    end
  end

  // ****************************************
  // Wake sources and bus idle count
  // ****************************************
  logic       pin_wake;
  logic       bus_active;
  logic [10:0] idle_cnt;
  logic       bus_idle_long;

  assign pin_wake   = |((gpio_s ^ gpio_prev) & i_change_enable);
  assign bus_active = !rx_s;

  always_ff @(posedge i_mclk) begin
    if (i_srst || bus_active) begin
      idle_cnt <= 11'h000;
    end else if (i_bit_tick && idle_cnt != `RSCS_IDLE_BITS) begin
      idle_cnt <= idle_cnt + 11'h001;
    end
  end

  assign bus_idle_long = (idle_cnt == `RSCS_IDLE_BITS);

  // ****************************************
  // Sequencer
  // ****************************************
  rscs_pkg::rscs_state_t state;
  rscs_pkg::rscs_state_t next_state;
  logic [22:0] power_up_delay_timer_cnt;
  logic [9:0]  ost_cnt;
  logic        power_up_delay_timer_done;
  logic        ost_done;
  logic        pu_sleep_pend;

  assign power_up_delay_timer_done = (power_up_delay_timer_cnt == 23'(POWER_UP_DELAY_TIMER_CYCLES - 1));
  assign ost_done  = i_osc_tick && (ost_cnt == `RSCS_OST_PERIODS - 10'h001);

  always_comb begin
    next_state = state;
    case (state)
      rscs_pkg::ST_POWER_UP_DELAY_TIMER: begin
        if (power_up_delay_timer_done) begin
          next_state = rscs_pkg::ST_OST;
        end
      end
      rscs_pkg::ST_OST: begin
        if (ost_done) begin
          next_state = rscs_pkg::ST_RUN;
        end
      end
      rscs_pkg::ST_RUN: begin
        if (ext_rst) begin
          next_state = rscs_pkg::ST_EXTRS;
        end else if (pu_sleep_pend && !bus_active) begin
          next_state = rscs_pkg::ST_SLEEP;
        end else if (i_sleep_enable_bit && i_normal_mode && bus_idle_long) begin
          next_state = rscs_pkg::ST_SLEEP;
        end
      end
      rscs_pkg::ST_SLEEP: begin
        if (ext_rst) begin
          next_state = rscs_pkg::ST_EXTRS;
        end else if (pin_wake || bus_active) begin
          next_state = rscs_pkg::ST_WAKE;
        end
      end
      rscs_pkg::ST_WAKE: begin
        if (ext_rst) begin
          next_state = rscs_pkg::ST_EXTRS;
        end else if (ost_done) begin
          next_state = rscs_pkg::ST_RUN;
        end
      end
      rscs_pkg::ST_EXTRS: begin
        if (!ext_rst) begin
          next_state = rscs_pkg::ST_RUN;
        end
      end
      default: next_state = rscs_pkg::ST_POWER_UP_DELAY_TIMER;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      state <= rscs_pkg::ST_POWER_UP_DELAY_TIMER;
    end else if (prog_mode) begin
      state <= rscs_pkg::ST_EXTRS;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst || state != rscs_pkg::ST_POWER_UP_DELAY_TIMER) begin
      power_up_delay_timer_cnt <= 23'h000000;
    end else begin
      power_up_delay_timer_cnt <= power_up_delay_timer_cnt + 23'h000001;
    end
  end

  // Counts only after power-on or on wake
  always_ff @(posedge i_mclk) begin
    if (i_srst || (state != rscs_pkg::ST_OST && state != rscs_pkg::ST_WAKE)) begin
      ost_cnt <= 10'h000;
    end else if (i_osc_tick) begin
      ost_cnt <= ost_cnt + 10'h001;
    end
  end

  // ****************************************
  // Listen-only power-up sleep
  // ****************************************
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      pu_sleep_pend <= 1'b0;
      o_listen_only <= 1'b0;
    end else if (state == rscs_pkg::ST_OST && ost_done) begin
      pu_sleep_pend <= i_sleep_after_powerup_bit;
      o_listen_only <= i_sleep_after_powerup_bit;
    end else if (state == rscs_pkg::ST_EXTRS) begin
      pu_sleep_pend <= 1'b0;
      o_listen_only <= 1'b0;
    end else begin
      if (state == rscs_pkg::ST_SLEEP || bus_active) begin
        pu_sleep_pend <= 1'b0;
      end
      if (o_listen_only && i_msg_valid && !o_drop_wake_frame) begin
        o_listen_only <= 1'b0;
      end
    end
  end

  // Waking frame ignored until the bus goes idle again
  always_ff @(posedge i_mclk) begin
    if (i_srst || state == rscs_pkg::ST_EXTRS) begin
      o_drop_wake_frame <= 1'b0;
    end else if (state == rscs_pkg::ST_SLEEP && bus_active && !ext_rst) begin
      o_drop_wake_frame <= 1'b1;
    end else if (state == rscs_pkg::ST_RUN && i_bit_tick && idle_cnt >= 11'h00b) begin
      o_drop_wake_frame <= 1'b0;
    end
  end

  // ****************************************
  // Pin hold and outputs
  // ****************************************
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_gpio_out <= 8'h00;
      o_gpio_oe  <= 8'h00;
    end else if (state != rscs_pkg::ST_SLEEP && next_state != rscs_pkg::ST_SLEEP) begin
      o_gpio_out <= i_core_gpio_out;
      o_gpio_oe  <= i_core_gpio_oe;
    end
  end

  assign o_core_reset  = (state == rscs_pkg::ST_POWER_UP_DELAY_TIMER) || (state == rscs_pkg::ST_OST) ||
                         (state == rscs_pkg::ST_EXTRS);
  assign o_sleep       = (state == rscs_pkg::ST_SLEEP);
  assign o_periph_halt = (state == rscs_pkg::ST_SLEEP) || (state == rscs_pkg::ST_WAKE);
  assign o_state       = state;

endmodule

// File: rscs_seq_assertions.sv
// Purpose: Port checks of the sequencer
// Assumes: Bound into rscs_sequencer
// Notes:   Start-up count allows one tick of slack
`timescale 1ns/1ns
module rscs_seq_assertions (
  input wire logic                  i_mclk,
  input wire logic                  i_srst,
  input wire logic [7:0]            i_gpio_pin,
  input wire logic                  i_osc_tick,
  input wire logic [13:0]           o_cfg_rdata,
  input wire logic                  o_prog_mode,
  input wire logic                  o_core_reset,
  input wire logic                  o_sleep,
  input wire logic                  o_periph_halt,
  input wire logic [7:0]            o_gpio_out,
  input wire logic [7:0]            o_gpio_oe,
  input wire rscs_pkg::rscs_state_t o_state
);
  // ***
  // Ticks seen in start-up
  // ***
  logic [10:0] tk;
  always_ff @(posedge i_mclk) begin
    if (o_state != rscs_pkg::ST_OST) begin
      tk <= 11'h000;
    end else if (i_osc_tick) begin
      tk <= tk + 11'h001;
    end
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  AST_HOLD: assert property (
    $past(i_srst) || $past(o_state) == rscs_pkg::ST_POWER_UP_DELAY_TIMER |-> o_core_reset && !o_sleep)
    else $error("core reset wrong");
  AST_HALT: assert property (
    o_sleep || o_state == rscs_pkg::ST_WAKE |-> o_periph_halt && !o_core_reset)
    else $error("halt wrong");
  AST_FREEZE: assert property (
    o_sleep && $past(o_sleep) |-> $stable(o_gpio_out) && $stable(o_gpio_oe))
    else $error("pins moved in sleep");
  AST_RD_GATE: assert property (!$past(o_prog_mode) |-> o_cfg_rdata == 14'h0000)
    else $error("config visible");
  AST_OST_LEN: assert property (
    $past(o_state) == rscs_pkg::ST_OST && o_state == rscs_pkg::ST_RUN |-> tk >= 11'h1ff && tk <= 11'h201)
    else $error("start-up length");
  AST_EXT_RUN: assert property (
    $past(o_state) == rscs_pkg::ST_EXTRS && o_state != rscs_pkg::ST_EXTRS |-> o_state == rscs_pkg::ST_RUN)
    else $error("start-up after pin reset");
  AST_WAKE_SRC: assert property (
    $past(o_state) == rscs_pkg::ST_SLEEP && o_state != rscs_pkg::ST_SLEEP
    |-> o_state inside {rscs_pkg::ST_WAKE, rscs_pkg::ST_EXTRS})
    else $error("bad sleep exit");
  AST_FILTER: assert property (
    o_state == rscs_pkg::ST_EXTRS && $past(o_state) != rscs_pkg::ST_EXTRS && !o_prog_mode && !$past(o_prog_mode)
    |-> !$past(i_gpio_pin[7], 4) && !$past(i_gpio_pin[7], 5))
    else $error("short pulse reset");
  COV_SLEEP: cover property (o_sleep);
  COV_WAKE: cover property (o_state == rscs_pkg::ST_WAKE);
  COV_PROG: cover property (o_prog_mode && o_cfg_rdata != 14'h0000);
endmodule
bind rscs_sequencer rscs_seq_assertions rscs_seq_assertions_i (.i_mclk, .i_srst, .i_gpio_pin, .i_osc_tick,
  .o_cfg_rdata, .o_prog_mode, .o_core_reset, .o_sleep, .o_periph_halt, .o_gpio_out, .o_gpio_oe, .o_state);

// File: rscs_far_model.sv
// Purpose: Serial programmer and CAN node
// Assumes: Released lines pulled high
// Notes:   A burst holds the bus dominant 8 cycles; in program mode it also raises data and clock
`timescale 1ns/1ns
module rscs_far_model (
  input  wire logic i_mclk,
  input  wire logic i_prog_req,
  input  wire logic i_burst,
  output logic      o_vpp,
  output logic      o_pdata,
  output logic      o_pclk,
  output logic      o_can_rx
);
  logic [3:0] dom = 4'h0;
  initial begin
    o_vpp = 1'b0;
    o_pdata = 1'b1;
    o_pclk = 1'b1;
  end
  always @(posedge i_mclk) begin
    o_pdata <= !i_prog_req || (o_vpp && i_burst);
    o_pclk <= !i_prog_req || (o_vpp && i_burst);
    o_vpp <= i_prog_req && (o_vpp || !o_pdata);
    dom <= i_burst ? 4'h8 : dom - {3'h0, dom != 4'h0};
  end
  assign o_can_rx = dom == 4'h0;
endmodule

// File: tb_top.sv
// Purpose: Self-checking bench of the sequencer
// Assumes: Short power-up timer, tick every other cycle
// Notes:   Far side in rscs_far_model
`timescale 1ns/1ns
module tb_top;
  typedef struct {logic [13:0] d; logic [13:0] rd; logic [1:0] osc;} rscs_row_t;
  rscs_row_t             rows [4] = '{'{14'h3ff8, 14'h07f8, 2'h0}, '{14'h0001, 14'h07f9, 2'h1},
                                      '{14'h3ffa, 14'h07fa, 2'h2}, '{14'h0007, 14'h07ff, 2'h3}};
  logic                  clk, srst, wr, er, slp, preq, burst, tick, vpp, pd, pc, rx, pm, crst, slpo, halt, drop;
  logic                  nm, msgv, pusb, pdo, pco, lo;
  logic [7:0]            gp, ce, cgo, gout, goe;
  logic [13:0]           addr, wd, rd;
  rscs_pkg::rscs_osc_t   osc;
  rscs_pkg::rscs_state_t st;
  int                    errors = 0;
  int                    compares = 0;
  rscs_far_model rscs_far_model_i (.i_mclk(clk), .i_prog_req(preq), .i_burst(burst),
    .o_vpp(vpp), .o_pdata(pd), .o_pclk(pc), .o_can_rx(rx));
  rscs_sequencer #(.POWER_UP_DELAY_TIMER_CYCLES(20)) rscs_sequencer_i (.i_mclk(clk), .i_srst(srst),
    .i_prog_voltage_pin(vpp), .i_prog_data_pin(pd), .i_prog_clock_pin(pc), .i_can_rx_pin(rx),
    .i_gpio_pin(gp), .i_change_enable(ce), .i_osc_tick(tick), .i_bit_tick(tick), .i_normal_mode(nm),
    .i_msg_valid(msgv), .i_sleep_enable_bit(slp), .i_sleep_after_powerup_bit(pusb),
    .i_core_gpio_out(cgo), .i_core_gpio_oe(~cgo), .i_cfg_addr(addr), .i_cfg_wdata(wd),
    .i_cfg_wr(wr), .i_cfg_erase(er), .o_cfg_rdata(rd), .o_prog_mode(pm), .o_prog_data(pdo),
    .o_prog_clock(pco), .o_osc_mode(osc), .o_core_reset(crst), .o_sleep(slpo), .o_periph_halt(halt),
    .o_listen_only(lo), .o_drop_wake_frame(drop), .o_gpio_out(gout), .o_gpio_oe(goe), .o_state(st));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) tick <= ~tick;
  // ***
  // Tasks
  // ***
  task automatic results;
    if (errors == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [13:0] e, input logic [13:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wait_st(input logic [2:0] s, input int lim);
    int n;
    n = 0;
    while (st !== s && n < lim) begin
      @(negedge clk);
      n++;
    end
    if (st !== s) begin
      chk("state", 14'(s), 14'(st));
      results();
    end
  endtask
  task automatic cfg(input logic [13:0] a, input logic [13:0] d, input logic w);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= w;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
    @(negedge clk);
  endtask
  // ***
  // Sequence
  // ***
  initial begin
    srst = 1'b1;
    tick = 1'b0;
    gp = 8'hff;
    ce = 8'h00;
    cgo = 8'h5a;
    addr = 14'h2007;
    wd = 14'h0000;
    wr = 1'b0;
    er = 1'b0;
    slp = 1'b0;
    preq = 1'b0;
    burst = 1'b0;
    nm = 1'b1;
    msgv = 1'b0;
    pusb = 1'b0;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    chk("core_reset", 14'h0001, 14'(crst));
    wait_st(rscs_pkg::ST_OST, 40);
    wait_st(rscs_pkg::ST_RUN, 1100);
    cfg(14'h2007, 14'h0000, 1'b1);
    chk("rdata_idle", 14'h0000, rd);
    @(posedge clk);
    preq <= 1'b1;
    wait_st(rscs_pkg::ST_EXTRS, 20);
    chk("prog_mode", 14'h0001, 14'(pm));
    @(posedge clk);
    burst <= 1'b1;
    repeat (5) @(negedge clk);
    chk("prog_data", 14'h0001, 14'(pdo));
    chk("prog_clock", 14'h0001, 14'(pco));
    @(posedge clk);
    burst <= 1'b0;
    @(posedge clk);
    er <= 1'b1;
    @(posedge clk);
    er <= 1'b0;
    cfg(14'h2007, 14'h0000, 1'b0);
    chk("erased", 14'h07ff, rd);
    chk("osc_default", 14'h0003, 14'(osc));
    for (int i = 0; i < 4; i++) begin
      cfg(14'h2007, rows[i].d, 1'b1);
      chk("rdata", rows[i].rd, rd);
      chk("osc", 14'(rows[i].osc), 14'(osc));
    end
    @(posedge clk);
    preq <= 1'b0;
    wait_st(rscs_pkg::ST_RUN, 20);
    chk("prog_gate", 14'h0000, 14'(pdo));
    @(posedge clk);
    gp[7] <= 1'b0;
    repeat (2) @(posedge clk);
    gp[7] <= 1'b1;
    repeat (12) @(negedge clk);
    chk("glitch", 14'(rscs_pkg::ST_RUN), 14'(st));
    @(posedge clk);
    gp[7] <= 1'b0;
    wait_st(rscs_pkg::ST_EXTRS, 20);
    chk("ext_reset", 14'h0001, 14'(crst));
    @(posedge clk);
    gp[7] <= 1'b1;
    wait_st(rscs_pkg::ST_RUN, 20);
    @(posedge clk);
    slp <= 1'b1;
    repeat (2500) @(negedge clk);
    chk("awake", 14'(rscs_pkg::ST_RUN), 14'(st));
    wait_st(rscs_pkg::ST_SLEEP, 600);
    chk("halt", 14'h0001, 14'(halt));
    chk("sleep", 14'h0001, 14'(slpo));
    @(posedge clk);
    cgo <= 8'ha5;
    gp[0] <= 1'b0;
    repeat (10) @(negedge clk);
    chk("frozen", 14'h005a, 14'(gout));
    chk("frozen_oe", 14'h00a5, 14'(goe));
    chk("no_wake", 14'(rscs_pkg::ST_SLEEP), 14'(st));
    @(posedge clk);
    ce <= 8'h01;
    gp[0] <= 1'b1;
    wait_st(rscs_pkg::ST_WAKE, 20);
    chk("wake_reset", 14'h0000, 14'(crst));
    wait_st(rscs_pkg::ST_RUN, 1100);
    repeat (2) @(negedge clk);
    chk("resume", 14'h00a5, 14'(gout));
    chk("resume_oe", 14'h005a, 14'(goe));
    wait_st(rscs_pkg::ST_SLEEP, 3000);
    @(posedge clk);
    burst <= 1'b1;
    @(posedge clk);
    burst <= 1'b0;
    wait_st(rscs_pkg::ST_WAKE, 20);
    repeat (2) @(negedge clk);
    chk("drop", 14'h0001, 14'(drop));
    // ***
    // Second power-on with listen-only sleep
    // ***
    srst <= 1'b1;
    pusb <= 1'b1;
    nm <= 1'b0;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    chk("osc_kept", 14'h0003, 14'(osc));
    wait_st(rscs_pkg::ST_SLEEP, 1100);
    chk("listen", 14'h0001, 14'(lo));
    @(posedge clk);
    burst <= 1'b1;
    @(posedge clk);
    burst <= 1'b0;
    wait_st(rscs_pkg::ST_WAKE, 20);
    @(posedge clk);
    msgv <= 1'b1;
    @(posedge clk);
    msgv <= 1'b0;
    wait_st(rscs_pkg::ST_RUN, 1100);
    repeat (4) @(negedge clk);
    chk("listen_drop", 14'h0001, 14'(lo));
    chk("drop_end", 14'h0000, 14'(drop));
    @(posedge clk);
    msgv <= 1'b1;
    @(posedge clk);
    msgv <= 1'b0;
    repeat (2) @(negedge clk);
    chk("listen_end", 14'h0000, 14'(lo));
    chk("not_normal", 14'(rscs_pkg::ST_RUN), 14'(st));
    @(posedge clk);
    nm <= 1'b1;
    wait_st(rscs_pkg::ST_SLEEP, 2000);
    results();
  end
endmodule
